// *** hw/bridge_interrupt_control_status.sv ***
`default_nettype none
// low half of the bridge interrupt control/status register and its outputs
module bridge_interrupt_control_status
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // pci-side register access
    input  wire logic        pci_wr_i,        // write strobe
    input  wire logic        pci_rd_i,        // read strobe
    input  wire logic [7:0]  pci_addr_i,      // byte offset
    input  wire logic [31:0] pci_wdata_i,     // write data
    input  wire logic [3:0]  pci_be_i,        // byte enables
    output logic      [31:0] pci_rdata_o,     // registered read data
    // local-side register access
    input  wire logic        loc_wr_i,
    input  wire logic        loc_rd_i,
    input  wire logic [7:0]  loc_addr_i,
    input  wire logic [31:0] loc_wdata_i,
    input  wire logic [3:0]  loc_be_i,
    output logic      [31:0] loc_rdata_o,
    // interrupt causes from the rest of the bridge
    input  wire logic        master_abort_i,  // received master abort status level
    input  wire logic        target_abort_i,  // target abort detected as master level
    input  wire logic        pci_parity_err_i,// pci parity error pulse
    input  wire logic        lpar_err_i,      // local data parity error pulse
    input  wire logic [3:0]  mbox_pci_wr_i,   // pci wrote mailbox zero..three
    input  wire logic [3:0]  mbox_loc_rd_i,   // local read of mailbox zero..three
    input  wire logic        pm_change_i,     // power state register changed pulse
    input  wire logic        ldb_pending_i,   // local doorbell bits nonzero
    input  wire logic [31:0] pdb_set_i,       // local writes set pci doorbell bits
    input  wire logic        local_int_n_i,   // local interrupt input pin, active low
    input  wire logic        retry_i,         // master retry pulse
    input  wire logic        xfer_done_i,     // master transfer ended
    // outputs
    output logic             local_error_out_o,
    output logic             serr_o,          // one-cycle serr request
    output logic             pci_int_o,       // pci interrupt level
    output logic             local_int_o,     // local interrupt level
    output logic             retry_abort_o,   // force target abort
    output logic      [31:0] pci_doorbell_o   // pci doorbell bits
);
    // stored control bits
    logic [17:0] ctrl_q;
    logic [17:0] ctrl_d;
    logic [3:0]  mbox_q;       // mailbox written, pending
    logic [31:0] pdb_q;        // pci doorbell bits
    logic        lin_s1_q;     // pin synchroniser stages
    logic        lin_s2_q;
    logic        lerr_q;       // latched local parity error for error pin
    logic        pci_par_q;    // pci parity error registered for one cycle for error pin

    // decodes
    wire pci_hit = pci_addr_i == irq_ctrl_pkg::CSR_PCI_OFS;
    wire loc_hit = loc_addr_i == irq_ctrl_pkg::CSR_LOC_OFS;
    // doorbell clear port, pci side only
    wire pdb_pci_hit = pci_addr_i == irq_ctrl_pkg::PDB_CLR_OFS;
    wire pci_w   = pci_wr_i & pci_hit;
    wire loc_w   = loc_wr_i & loc_hit & !pci_w;   // pci wins a collision
    wire [31:0] wdata = pci_w ? pci_wdata_i : loc_wdata_i;
    wire [3:0]  wbe   = pci_w ? pci_be_i : loc_be_i;
    wire        wr_any = pci_w | loc_w;
    wire [17:0] be_mask = {{2{wbe[2]}}, {8{wbe[1]}}, {8{wbe[0]}}};
    wire [17:0] wmask = be_mask & irq_ctrl_pkg::CTRL_WMASK & {18{wr_any}};

    // gated causes
    wire lin_act   = !lin_s2_q;
    wire pdb_act   = |pdb_q;
    wire abort_act = master_abort_i | target_abort_i;
    irq_src_if src();
    assign src.pci_en  = ctrl_q[irq_ctrl_pkg::B_PCI_EN];
    assign src.lout_en = ctrl_q[irq_ctrl_pkg::B_LOUT_EN];
    wire lin_req   = lin_act & ctrl_q[irq_ctrl_pkg::B_LIN_EN];
    wire abort_req = abort_act & ctrl_q[irq_ctrl_pkg::B_ABORT_EN];
    wire pdb_req   = pdb_act & ctrl_q[irq_ctrl_pkg::B_PDB_EN];
    assign src.pci_req = {lin_req, abort_req, pdb_req};
    wire ldb_req   = ldb_pending_i & ctrl_q[irq_ctrl_pkg::B_LDB_EN];
    wire pm_req    = ctrl_q[irq_ctrl_pkg::B_PM_PEND] & ctrl_q[irq_ctrl_pkg::B_PM_EN];
    wire mbox_req  = (|mbox_q) & ctrl_q[irq_ctrl_pkg::B_MBOX_EN];
    assign src.loc_req = {ldb_req, pm_req, mbox_req};
    irq_combiner u_comb (.s(src));

    // serr on 0 to 1 write
    wire serr_fire = wr_any & wbe[0] & wdata[irq_ctrl_pkg::B_SERR_GEN]
                     & !ctrl_q[irq_ctrl_pkg::B_SERR_GEN];

    wire [31:0] rd_word = {14'h0000, ctrl_q[17:16], lin_act, abort_act, pdb_act,
                           ctrl_q[12:0]};

    wire err_now = ctrl_q[irq_ctrl_pkg::B_ERR_ABORT_EN] & (master_abort_i
                 | (ctrl_q[irq_ctrl_pkg::B_LPAR_EN] & lerr_q))
                 | (ctrl_q[irq_ctrl_pkg::B_ERR_PCIPAR_EN] & pci_par_q);

    // next control word: writes merged, w1c bits handled after
    always_comb
    begin
        ctrl_d = (ctrl_q & ~wmask) | (wdata[17:0] & wmask);
        ctrl_d[irq_ctrl_pkg::B_PM_PEND] = (ctrl_q[irq_ctrl_pkg::B_PM_PEND]
            & !(wr_any & wbe[0] & wdata[irq_ctrl_pkg::B_PM_PEND])) | pm_change_i;
        // local parity status w1c, set wins
        ctrl_d[irq_ctrl_pkg::B_LPAR_STAT] = (ctrl_q[irq_ctrl_pkg::B_LPAR_STAT]
            & !(wr_any & wbe[0] & wdata[irq_ctrl_pkg::B_LPAR_STAT])) | lpar_err_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ctrl_q <= irq_ctrl_pkg::CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    // mailbox pending set by pci write, cleared by local read
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            mbox_q <= 4'h0;
        else
            mbox_q <= (mbox_q & ~mbox_loc_rd_i) | mbox_pci_wr_i;
    end

    // doorbell set by local, pci w1c, set wins
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pdb_q <= 32'h0000_0000;
        else if (pci_wr_i & pdb_pci_hit)
            pdb_q <= (pdb_q & ~pci_wdata_i) | pdb_set_i;
        else
            pdb_q <= pdb_q | pdb_set_i;
    end

    // two-stage sync of the local interrupt pin
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            lin_s1_q <= 1'b1;
            lin_s2_q <= 1'b1;
        end
        else
        begin
            lin_s1_q <= local_int_n_i;
            lin_s2_q <= lin_s1_q;
        end
    end

    // local parity held until status cleared, pci parity only registered for one cycle
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            lerr_q    <= 1'b0;
            pci_par_q <= 1'b0;
        end
        else
        begin
            lerr_q    <= ctrl_d[irq_ctrl_pkg::B_LPAR_STAT];
            pci_par_q <= pci_parity_err_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            local_error_out_o <= 1'b0;
            serr_o            <= 1'b0;
            pci_int_o         <= 1'b0;
            local_int_o       <= 1'b0;
            pci_rdata_o       <= 32'h0000_0000;
            loc_rdata_o       <= 32'h0000_0000;
            pci_doorbell_o    <= 32'h0000_0000;
        end
        else
        begin
            local_error_out_o <= err_now;
            serr_o            <= serr_fire;
            pci_int_o         <= src.pci_irq;
            local_int_o       <= src.loc_irq;
            pci_rdata_o       <= (pci_rd_i & pci_hit) ? rd_word : 32'h0000_0000;
            loc_rdata_o       <= (loc_rd_i & loc_hit) ? rd_word : 32'h0000_0000;
            pci_doorbell_o    <= pdb_q;
        end
    end

    // retry counter
    retry_limiter u_retry (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .enable_i  (ctrl_q[irq_ctrl_pkg::B_RETRY_EN]),
        .retry_i   (retry_i),
        .done_i    (xfer_done_i),
        .abort_o   (retry_abort_o)
    );

    // pci interrupt off when master enable clear
    property p_pci_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        !src.pci_en |=> !pci_int_o;
    endproperty
    a_pci_gate: assert property (p_pci_gate) else $error("pci irq while disabled");

    property p_mbox;
        @(posedge clk_i) disable iff (sys_rst_i)
        (|mbox_pci_wr_i) && ctrl_q[3] && ctrl_q[16] ##1 ctrl_q[3] && ctrl_q[16]
        |=> local_int_o;
    endproperty
    a_mbox: assert property (p_mbox) else $error("mailbox irq missing");

    property p_mbox_rd;
        @(posedge clk_i) disable iff (sys_rst_i)
        mbox_loc_rd_i[0] && !mbox_pci_wr_i[0] |=> !mbox_q[0];
    endproperty
    a_mbox_rd: assert property (p_mbox_rd) else $error("mailbox not cleared");

    // serr pulse on 0 to 1 write
    property p_serr;
        @(posedge clk_i) disable iff (sys_rst_i)
        serr_fire |=> serr_o && ctrl_q[irq_ctrl_pkg::B_SERR_GEN];
    endproperty
    a_serr: assert property (p_serr) else $error("serr not pulsed");

    property p_pm;
        @(posedge clk_i) disable iff (sys_rst_i)
        pm_change_i |=> ctrl_q[5];
    endproperty
    a_pm: assert property (p_pm) else $error("pm pending lost");

    property p_lpar;
        @(posedge clk_i) disable iff (sys_rst_i)
        lpar_err_i |=> ctrl_q[7];
    endproperty
    a_lpar: assert property (p_lpar) else $error("parity status lost");

    property p_err;
        @(posedge clk_i) disable iff (sys_rst_i)
        ctrl_q[0] && master_abort_i |=> local_error_out_o;
    endproperty
    a_err: assert property (p_err) else $error("error pin missing");

    property p_ro;
        @(posedge clk_i) disable iff (sys_rst_i)
        loc_rd_i && loc_hit && pdb_act |=> loc_rdata_o[irq_ctrl_pkg::B_PDB_ACT];
    endproperty
    a_ro: assert property (p_ro) else $error("active flag not read back");

    property p_pdb;
        @(posedge clk_i) disable iff (sys_rst_i)
        pdb_act && ctrl_q[irq_ctrl_pkg::B_PDB_EN] && ctrl_q[irq_ctrl_pkg::B_PCI_EN] |=> pci_int_o;
    endproperty
    a_pdb: assert property (p_pdb) else $error("doorbell irq missing");

    property p_abort;
        @(posedge clk_i) disable iff (sys_rst_i)
        abort_act && ctrl_q[irq_ctrl_pkg::B_ABORT_EN] && ctrl_q[irq_ctrl_pkg::B_PCI_EN]
        |=> pci_int_o;
    endproperty
    a_abort: assert property (p_abort) else $error("abort irq missing");

    property p_lin;
        @(posedge clk_i) disable iff (sys_rst_i)
        lin_act && ctrl_q[irq_ctrl_pkg::B_LIN_EN] && ctrl_q[irq_ctrl_pkg::B_PCI_EN] |=> pci_int_o;
    endproperty
    a_lin: assert property (p_lin) else $error("local input irq missing");

    // local irq off when output disabled
    property p_lout_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        !ctrl_q[irq_ctrl_pkg::B_LOUT_EN] |=> !local_int_o;
    endproperty
    a_lout_gate: assert property (p_lout_gate) else $error("local irq while disabled");

    // pending power change raises local irq
    property p_pm_irq;
        @(posedge clk_i) disable iff (sys_rst_i)
        ctrl_q[irq_ctrl_pkg::B_PM_PEND] && ctrl_q[irq_ctrl_pkg::B_PM_EN]
        && ctrl_q[irq_ctrl_pkg::B_LOUT_EN] |=> local_int_o;
    endproperty
    a_pm_irq: assert property (p_pm_irq) else $error("power irq missing");

    // no forced abort while retry limit off
    property p_retry_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        !ctrl_q[irq_ctrl_pkg::B_RETRY_EN] |=> !retry_abort_o;
    endproperty
    a_retry_gate: assert property (p_retry_gate) else $error("abort without limit");
endmodule
`default_nettype wire

// *** hw/interrupt_control_status_pkg.sv ***
// Contract
// - abort status plus bit0 drives local error; code uses master abort only, not target abort
// - bit1 flags pci parity on local error
// - writing 1 over 0 at bit2 pulses serr
// - mailbox writes raise local irq with bits 3,16
// - local mailbox read drops mailbox interrupt
// - bit4 raises local irq on state change
// - bit5 pending on power change, w1c
// - bit6 and bit0 route local parity error
// - bit7 sets on local parity error, w1c
// - bit8 master pci enable, resets to 1
// - bits 9,8 gate pci doorbell interrupt
// - bits 10,8 gate abort interrupt
// - bits 11,8 gate local input interrupt
// - bit12 aborts after 256 retries
// - bits 13-15 read-only active flags
// - bit16 local output enable, resets to 1
// - bit17 gates local doorbell interrupt
// - doorbell set by local, cleared by pci w1c
`default_nettype none
package irq_ctrl_pkg;
    // register offsets (pci side and local side)
    localparam logic [7:0] CSR_PCI_OFS     = 8'h68;
    localparam logic [7:0] CSR_LOC_OFS     = 8'he8;
    // pci-side offset where the host clears doorbell bits
    localparam logic [7:0] PDB_CLR_OFS     = 8'h64;
    // bit positions in the control/status word
    localparam int B_ERR_ABORT_EN   = 0;
    localparam int B_ERR_PCIPAR_EN  = 1;
    localparam int B_SERR_GEN       = 2;
    localparam int B_MBOX_EN        = 3;
    localparam int B_PM_EN          = 4;
    localparam int B_PM_PEND        = 5;
    localparam int B_LPAR_EN        = 6;
    localparam int B_LPAR_STAT      = 7;
    localparam int B_PCI_EN         = 8;
    localparam int B_PDB_EN         = 9;
    localparam int B_ABORT_EN       = 10;
    localparam int B_LIN_EN         = 11;
    localparam int B_RETRY_EN       = 12;
    localparam int B_PDB_ACT        = 13;
    localparam int B_ABORT_ACT      = 14;
    localparam int B_LIN_ACT        = 15;
    localparam int B_LOUT_EN        = 16;
    localparam int B_LDB_EN         = 17;
    // writable storage bits and reset value of the low half
    localparam logic [17:0] CTRL_WMASK = 18'h31fdf;
    localparam logic [17:0] CTRL_RESET = 18'h10100;
    // retry limit before an abort is forced
    localparam logic [8:0]  RETRY_LIMIT = 9'h100;
endpackage
`default_nettype wire

// *** hw/irq_combiner.sv ***
`default_nettype none
// merges enabled causes into level interrupt requests
module irq_combiner
(
    irq_src_if.comb s
);
    assign s.pci_irq = s.pci_en & (|s.pci_req);
    assign s.loc_irq = s.lout_en & (|s.loc_req);
endmodule
`default_nettype wire

// *** hw/irq_src_if.sv ***
`default_nettype none
// groups the gated interrupt causes between the top and the combiner
interface irq_src_if;
    logic       pci_en;   // master pci enable
    logic       lout_en;  // local output enable
    logic [2:0] pci_req;  // enabled pci causes: doorbell, abort, local in
    logic [2:0] loc_req;  // enabled local causes: mailbox, power, local doorbell
    logic       pci_irq;  // combined pci level
    logic       loc_irq;  // combined local level
    modport src (output pci_en, lout_en, pci_req, loc_req, input pci_irq, loc_irq);
    modport comb (input pci_en, lout_en, pci_req, loc_req, output pci_irq, loc_irq);
endinterface
`default_nettype wire

// *** hw/retry_limiter.sv ***
`default_nettype none
// counts consecutive master retries to one target
module retry_limiter
(
    input  wire logic clk_i,       // system clock
    input  wire logic sys_rst_i,   // async reset
    input  wire logic enable_i,    // retry abort enabled
    input  wire logic retry_i,     // one pulse per retry
    input  wire logic done_i,      // transfer ended, restart count
    output logic      abort_o      // one-cycle forced abort
);
    logic [8:0] cnt_q;             // retries seen so far
    wire        hit = (cnt_q == irq_ctrl_pkg::RETRY_LIMIT - 9'h001) & retry_i & enable_i;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cnt_q <= 9'h000;
        else if (done_i | hit | !enable_i)
            cnt_q <= 9'h000;
        else if (retry_i)
            cnt_q <= cnt_q + 9'h001;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            abort_o <= 1'b0;
        else
            abort_o <= hit;
    end
endmodule
`default_nettype wire

// *** testbench/bridge_far_model.sv ***
`default_nettype none
// far side: pci host and local cpu making register accesses
module bridge_far_model
(
    // clock
    input  wire logic        clk_i,
    // pci host access
    output logic             pci_wr_o    = 1'b0,
    output logic             pci_rd_o    = 1'b0,
    output logic      [7:0]  pci_addr_o  = 8'h00,
    output logic      [31:0] pci_wdata_o = 32'h0,
    input  wire logic [31:0] pci_rdata_i,
    // local cpu access
    output logic             loc_wr_o    = 1'b0,
    output logic             loc_rd_o    = 1'b0,
    output logic      [7:0]  loc_addr_o  = 8'h00,
    output logic      [31:0] loc_wdata_o = 32'h0,
    input  wire logic [31:0] loc_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // one access; strobe, address and data held through the taking edge
    task automatic acc(input logic pci, input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        #5;
        {pci_wr_o, pci_rd_o} = {pci & wr, pci & !wr};
        {loc_wr_o, loc_rd_o} = {!pci & wr, !pci & !wr};
        {pci_addr_o, loc_addr_o} = {a, a};
        {pci_wdata_o, loc_wdata_o} = {d, d};
        @(posedge clk_i);
        #5;
        // answer was registered on the taking edge, settled by now
        q = pci ? pci_rdata_i : loc_rdata_i;
        {pci_wr_o, pci_rd_o, loc_wr_o, loc_rd_o} = 4'h0;
        // released data shows the inverse, never a stale copy
        {pci_wdata_o, loc_wdata_o} = ~{d, d};
    endtask
endmodule
`default_nettype wire

// *** testbench/bridge_interrupt_control_status_bench.sv ***
`default_nettype none
module bridge_interrupt_control_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus, quiet at time zero with reset asserted
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, local_int_n_i = 1'b1;
    logic        pci_wr_i, pci_rd_i, loc_wr_i, loc_rd_i;
    logic [7:0]  pci_addr_i, loc_addr_i;
    logic [31:0] pci_wdata_i, loc_wdata_i, pdb_set_i = 32'h0;
    logic [3:0]  pci_be_i = 4'hf, loc_be_i = 4'hf, mbox_pci_wr_i = 4'h0, mbox_loc_rd_i = 4'h0;
    logic        master_abort_i = 1'b0, target_abort_i = 1'b0, pci_parity_err_i = 1'b0;
    logic        lpar_err_i = 1'b0, pm_change_i = 1'b0, ldb_pending_i = 1'b0;
    logic        retry_i = 1'b0, xfer_done_i = 1'b0;
    // design outputs and the last read
    logic [31:0] pci_rdata_o, loc_rdata_o, pci_doorbell_o, q;
    logic        local_error_out_o, serr_o, pci_int_o, local_int_o, retry_abort_o;
    // positions in the output bundle
    localparam int LERR = 4, SERR = 3, PINT = 2, LINT = 1;
    wire   [4:0] outs = {local_error_out_o, serr_o, pci_int_o, local_int_o, retry_abort_o};
    int          err_count = 0, checks_done = 0, aborts = 0, lerr_hits = 0;

    bridge_interrupt_control_status DUT (.*);
    // register traffic from both sides
    bridge_far_model hm
    (
        .clk_i(clk_i), .pci_wr_o(pci_wr_i), .pci_rd_o(pci_rd_i), .pci_addr_o(pci_addr_i),
        .pci_wdata_o(pci_wdata_i), .pci_rdata_i(pci_rdata_o), .loc_wr_o(loc_wr_i),
        .loc_rd_o(loc_rd_i), .loc_addr_o(loc_addr_i), .loc_wdata_o(loc_wdata_i),
        .loc_rdata_i(loc_rdata_o)
    );
    initial forever #25 clk_i = ~clk_i;
    // pulses are counted, so their exact cycle does not matter
    always @(posedge clk_i) aborts <= aborts + int'(retry_abort_o === 1'b1);
    always @(posedge clk_i) lerr_hits <= lerr_hits + int'(local_error_out_o === 1'b1);

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // wait n edges, act just after the last
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    task automatic late(input int n, input string s, input int i, input logic e);
        cyc(n);
        check(s, 32'(outs[i]), 32'(e));
    endtask
    // one-cycle pulse, then one idle cycle
    task automatic tick(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    // write from the pci side, read back from the local side
    task automatic wr(input logic [31:0] d);
        hm.acc(1'b1, 1'b1, 8'h68, d, q);
    endtask
    task automatic rd(input string n, input logic [31:0] e);
        hm.acc(1'b0, 1'b0, 8'he8, 32'h0, q);
        check(n, q, e);
    endtask
    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_reg();
        rd("reset", {14'h0, irq_ctrl_pkg::CTRL_RESET});
        wr(32'h0000e104);
        check("serr", 32'(serr_o), 1);
        late(1, "serr1", SERR, 0);
        rd("ro", 32'h00000104);
        wr(32'h00010104);
        check("serr0", 32'(serr_o), 0);
        // pci host reads the same word back
        hm.acc(1'b1, 1'b0, 8'h68, 32'h0, q);
        check("pcird", q, 32'h00010104);
        // local cpu writes the word itself
        hm.acc(1'b0, 1'b1, 8'he8, 32'h00010100, q);
        rd("locwr", 32'h00010100);
    endtask
    task automatic t_pci();
        for (int k = 0; k < 3; k++)
        begin
            wr(32'h00010100 | (32'h200 << k));
            master_abort_i = (k == 1);
            local_int_n_i = (k != 2);
            // local cpu sets doorbell bit 0, first pass (k 0) only
            pdb_set_i = 32'(k == 0);
            cyc(1);
            pdb_set_i = 32'h0;
            late(5, "pint", PINT, 1);
            check("pdb", pci_doorbell_o, 32'(k == 0));
            rd("act", 32'h00010100 | (32'h2200 << k));
            wr(32'h00010000 | (32'h200 << k));
            late(3, "pmask", PINT, 0);
            wr(32'h00010100 | (32'h200 << k));
            {master_abort_i, local_int_n_i} = 2'b01;
            // host clears a doorbell bit by writing one
            hm.acc(1'b1, 1'b1, 8'h64, 32'h1, q);
            late(5, "pclr", PINT, 0);
        end
        // target abort seen as master
        wr(32'h00010500);
        target_abort_i = 1'b1;
        late(3, "tabort", PINT, 1);
        target_abort_i = 1'b0;
        late(3, "taclr", PINT, 0);
    endtask
    task automatic t_loc();
        wr(32'h00030118);
        for (int k = 0; k < 4; k++)
        begin
            mbox_pci_wr_i = 4'h1 << k;
            cyc(1);
            mbox_pci_wr_i = 4'h0;
            late(3, "mbox", LINT, 1);
            mbox_loc_rd_i = 4'h1 << k;
            cyc(1);
            mbox_loc_rd_i = 4'h0;
            late(3, "mbrd", LINT, 0);
        end
        tick(pm_change_i);
        late(2, "pm", LINT, 1);
        rd("pmpend", 32'h00030138);
        wr(32'h00030138);
        late(3, "pmclr", LINT, 0);
        ldb_pending_i = 1'b1;
        late(3, "ldb", LINT, 1);
        ldb_pending_i = 1'b0;
        late(3, "ldbclr", LINT, 0);
        // output enable off masks the local doorbell cause
        wr(32'h00020100);
        ldb_pending_i = 1'b1;
        late(3, "loutoff", LINT, 0);
        ldb_pending_i = 1'b0;
    endtask
    task automatic t_err();
        int h;
        wr(32'h00010101);
        master_abort_i = 1'b1;
        late(3, "abort", LERR, 1);
        master_abort_i = 1'b0;
        late(3, "abend", LERR, 0);
        // parity with bit1 clear stays off the pin
        h = lerr_hits;
        tick(pci_parity_err_i);
        cyc(3);
        check("parnone", lerr_hits, h);
        wr(32'h00010142);
        h = lerr_hits;
        tick(pci_parity_err_i);
        cyc(3);
        check("parity", 32'(lerr_hits > h), 1);
        tick(lpar_err_i);
        late(3, "lparoff", LERR, 0);
        rd("lpstat", 32'h000101c2);
        wr(32'h00010143);
        late(3, "lpar", LERR, 1);
        wr(32'h000101c3);
        rd("lpw1c", 32'h00010143);
        late(3, "lpclr", LERR, 0);
    endtask
    task automatic t_retry();
        wr(32'h00011100);
        repeat (255) tick(retry_i);
        cyc(3);
        check("r255", aborts, 0);
        tick(retry_i);
        cyc(3);
        check("r256", aborts, 1);
        tick(xfer_done_i);
        wr(32'h00010100);
        repeat (300) tick(retry_i);
        cyc(3);
        check("nolimit", aborts, 1);
    endtask

    initial
    begin
        repeat (20) @(posedge clk_i);
        #5;
        sys_rst_i = 1'b0;
        t_reg();
        t_pci();
        t_loc();
        t_err();
        t_retry();
        test_done();
    end
    // hang guard, well beyond the roughly 1340 cycles the tests need
    initial
    begin
        #1ms;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
